// File: tiec_pkg.sv
package tiec_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL0 = 8'h00;
  localparam logic [7:0] ADDR_CONTROL1 = 8'h04;
  localparam logic [7:0] ADDR_IO_CONTROL1 = 8'h08;
  localparam logic [7:0] ADDR_COMPARE0 = 8'h0c;
  localparam logic [7:0] ADDR_COMPARE1 = 8'h10;
  localparam logic [7:0] ADDR_COUNTER = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL0_COUNT_ENABLE_POS = 7;
  localparam int CTL1_SOFTWARE_TRIGGER_POS = 6;
  localparam int CTL1_EXT_CLOCK_ENABLE_POS = 5;
  localparam int CTL1_MODE_LSB = 0;
  localparam int IOC1_EDGE_SELECT_LSB = 0;
  localparam int IOC1_OUT0_ENABLE_POS = 4;
  localparam int IOC1_OUT1_ENABLE_POS = 5;
  localparam int STATUS_OVERFLOW_POS = 0;
  localparam int STATUS_OUT0_POS = 1;
  localparam int STATUS_OUT1_POS = 2;
  // ************************************************************
  // codes and reset values
  // ************************************************************
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EVENT_COUNT = 3'h1;
  localparam logic [15:0] COUNTER_RESET = 16'hffff;
  localparam logic [15:0] COUNTER_ZERO = 16'h0000;
  localparam logic [15:0] COUNTER_MAX = 16'hffff;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage : tiec_pkg

// File: tiec_edge_detect.sv
`timescale 1ns/10ps
module tiec_edge_detect (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // sampled pin and edge choice
  input wire logic pin_in,
  input wire logic [1:0] edge_select,
  // result
  output logic edge_pulse
);
  logic pin_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 1'b0;
    end else if (clk_en) begin
      pin_prev <= pin_in;
    end
  end

  always_comb begin
    case (edge_select)
      tiec_pkg::EDGE_RISING: edge_pulse = pin_in & ~pin_prev;
      tiec_pkg::EDGE_FALLING: edge_pulse = ~pin_in & pin_prev;
      tiec_pkg::EDGE_BOTH: edge_pulse = pin_in ^ pin_prev;
      default: edge_pulse = 1'b0;
    endcase
  end
endmodule : tiec_edge_detect

// File: tiec_timer.sv
`timescale 1ns/10ps
// Operation
// - mode 000 interval, 001 event count
// - external clock only from capture input0
// - interval start: wrap, toggle0, load buffer0
// - match0 clears, toggles output0, raises irq0
// - compare1 buffered, irq1 on match
// - compare0 zero: irq0 every count
// - compare FFFF: match, no overflow
// - event FFFF: clear, irq0, no overflow
// - compare0 write reaches buffer one cycle later, while enabled
// - compare1 below: irq1, toggle output1
// - compare1 above: no irq1, output1 holds
// - event start: wrap, load, count edges
// - event match0 clears, raises irq0
// - event mode drives no timer output
// - event irq1 once when compare1 below
// - counter read returns live count once running
// - disabled counter reads zero
module tiec_timer #(
  parameter int PRESCALE = 1
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic capture_trigger_input0,
  input wire logic external_trigger_input,
  output logic timer_output0,
  output logic timer_output1,
  // interrupt requests
  output logic match_irq0,
  output logic match_irq1,
  output logic overflow_irq
);
  // ************************************************************
  // registers
  // ************************************************************
  typedef enum logic [1:0] {
    TIEC_IDLE = 2'b00,
    TIEC_RUN = 2'b01
  } tiec_state_t;

  tiec_state_t state;
  logic count_enable_bit;
  logic software_trigger_bit;
  logic external_event_clock_enable;
  logic [2:0] mode_select;
  logic [1:0] capture_edge_select;
  logic out0_enable;
  logic out1_enable;
  logic [15:0] compare_reg0;
  logic [15:0] compare_reg1;
  logic [15:0] compare_buf0;
  logic [15:0] compare_buf1;
  logic [15:0] counter;
  logic overflow_flag;
  logic [15:0] prescale_cnt;
  logic event_edge;
  logic count_tick;
  logic match0;
  logic match1;
  logic wr_en;
  logic rd_en;
  logic mode_ok;
  logic interval_mode;

  // single-cycle apb: no wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & ~penable & ~pwrite & clk_en;
  assign interval_mode = (mode_select == tiec_pkg::MODE_INTERVAL);
  assign mode_ok = interval_mode | (mode_select == tiec_pkg::MODE_EVENT_COUNT);

  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      tiec_pkg::ADDR_CONTROL0, tiec_pkg::ADDR_CONTROL1, tiec_pkg::ADDR_IO_CONTROL1,
      tiec_pkg::ADDR_COMPARE0, tiec_pkg::ADDR_COMPARE1, tiec_pkg::ADDR_COUNTER,
      tiec_pkg::ADDR_STATUS: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction : addr_known

  assign pslverr = psel & penable & ~addr_known(paddr);

  // ************************************************************
  // count clock source
  // ************************************************************
  // edges come from capture_trigger_input0 only; the trigger pin is ignored
  // fixed rising edge: the stored edge select never reaches this path
  tiec_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in(capture_trigger_input0),
    .edge_select(tiec_pkg::EDGE_RISING),
    .edge_pulse(event_edge)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_cnt <= 16'h0000;
    end else if (clk_en) begin
      // divider restarts while stopped, so the first tick is one period away
      if (!count_enable_bit || prescale_cnt == 16'(PRESCALE - 1)) begin
        prescale_cnt <= 16'h0000;
      end else begin
        prescale_cnt <= prescale_cnt + 16'h0001;
      end
    end
  end

  // event mode always counts pin edges; interval mode may choose them too
  always_comb begin
    if (!interval_mode || external_event_clock_enable) begin
      count_tick = event_edge;
    end else begin
      count_tick = (prescale_cnt == 16'(PRESCALE - 1));
    end
  end

  // same equality for both channels, qualified by run state and tick
  function automatic logic hits(input logic [15:0] cnt, input logic [15:0] cmp);
    hits = (cnt == cmp);
  endfunction : hits

  assign match0 = (state == TIEC_RUN) & count_tick & hits(counter, compare_buf0);
  assign match1 = (state == TIEC_RUN) & count_tick & hits(counter, compare_buf1);

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_enable_bit <= 1'b0;
      software_trigger_bit <= 1'b0;
      external_event_clock_enable <= 1'b0;
      mode_select <= tiec_pkg::MODE_INTERVAL;
      capture_edge_select <= tiec_pkg::EDGE_NONE;
      out0_enable <= 1'b0;
      out1_enable <= 1'b0;
      compare_reg0 <= tiec_pkg::COMPARE_RESET;
      compare_reg1 <= tiec_pkg::COMPARE_RESET;
    end else if (clk_en) begin
      // trigger bit has no effect in these modes and reads back zero
      software_trigger_bit <= 1'b0;
      if (wr_en) begin
        case (paddr)
          tiec_pkg::ADDR_CONTROL0:
            count_enable_bit <= pwdata[tiec_pkg::CTL0_COUNT_ENABLE_POS];
          tiec_pkg::ADDR_CONTROL1: begin
            software_trigger_bit <= pwdata[tiec_pkg::CTL1_SOFTWARE_TRIGGER_POS];
            external_event_clock_enable <= pwdata[tiec_pkg::CTL1_EXT_CLOCK_ENABLE_POS];
            mode_select <= pwdata[tiec_pkg::CTL1_MODE_LSB +: 3];
          end
          tiec_pkg::ADDR_IO_CONTROL1: begin
            capture_edge_select <= pwdata[tiec_pkg::IOC1_EDGE_SELECT_LSB +: 2];
            out0_enable <= pwdata[tiec_pkg::IOC1_OUT0_ENABLE_POS];
            out1_enable <= pwdata[tiec_pkg::IOC1_OUT1_ENABLE_POS];
          end
          tiec_pkg::ADDR_COMPARE0: compare_reg0 <= pwdata[15:0];
          tiec_pkg::ADDR_COMPARE1: compare_reg1 <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // counter and compare buffers
  // ************************************************************
  // anytime write: buffers follow registers while running, so a lowered
  // compare0 below the count runs to wrap first (stop first to avoid)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TIEC_IDLE;
      counter <= tiec_pkg::COUNTER_RESET;
      compare_buf0 <= tiec_pkg::COMPARE_RESET;
      compare_buf1 <= tiec_pkg::COMPARE_RESET;
    end else if (clk_en) begin
      if (!count_enable_bit || !mode_ok) begin
        state <= TIEC_IDLE;
        counter <= tiec_pkg::COUNTER_RESET;
      end else begin
        compare_buf0 <= compare_reg0;
        compare_buf1 <= compare_reg1;
        case (state)
          TIEC_IDLE: begin
            // first count edge wraps FFFF to 0000
            if (count_tick) begin
              counter <= tiec_pkg::COUNTER_ZERO;
              state <= TIEC_RUN;
            end
          end
          TIEC_RUN: begin
            if (match0) begin
              counter <= tiec_pkg::COUNTER_ZERO;
            end else if (count_tick) begin
              counter <= counter + 16'h0001;
            end
          end
          default: state <= TIEC_IDLE;
        endcase
      end
    end
  end

  // overflow only on a free wrap, never on a match at FFFF
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      overflow_irq <= 1'b0;
    end else if (clk_en) begin
      overflow_irq <= 1'b0;
      // writing 1 does nothing: software can only clear the flag
      // a set in the same cycle wins over the clear
      if (state == TIEC_RUN && count_tick && !match0 && counter == tiec_pkg::COUNTER_MAX
          && count_enable_bit) begin
        overflow_flag <= 1'b1;
        overflow_irq <= 1'b1;
      end else if (wr_en && paddr == tiec_pkg::ADDR_STATUS
                   && !pwdata[tiec_pkg::STATUS_OVERFLOW_POS]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // outputs and interrupts
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output0 <= 1'b0;
      timer_output1 <= 1'b0;
      match_irq0 <= 1'b0;
      match_irq1 <= 1'b0;
    end else if (clk_en) begin
      match_irq0 <= match0 & count_enable_bit;
      // compare1 above compare0 never matches: no irq, level held
      match_irq1 <= match1 & count_enable_bit;
      if (!count_enable_bit) begin
        timer_output0 <= 1'b0;
        timer_output1 <= 1'b0;
      end else if (interval_mode && out0_enable) begin
        // event mode leaves outputs untouched
        if ((state == TIEC_IDLE && count_tick) || match0) begin
          timer_output0 <= ~timer_output0;
        end
      end
      if (count_enable_bit && interval_mode && out1_enable && match1) begin
        timer_output1 <= ~timer_output1;
      end
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      // loaded in the setup cycle, so a read needs no wait state
      case (paddr)
        tiec_pkg::ADDR_CONTROL0:
          prdata <= {24'h000000, count_enable_bit, 7'h00};
        tiec_pkg::ADDR_CONTROL1:
          prdata <= {26'h0000000, external_event_clock_enable, 2'h0, mode_select};
        tiec_pkg::ADDR_IO_CONTROL1:
          prdata <= {26'h0000000, out1_enable, out0_enable, 2'h0, capture_edge_select};
        tiec_pkg::ADDR_COMPARE0: prdata <= {16'h0000, compare_reg0};
        tiec_pkg::ADDR_COMPARE1: prdata <= {16'h0000, compare_reg1};
        // live count while enabled and running, zero while stopped or before the first count tick
        tiec_pkg::ADDR_COUNTER:
          prdata <= (count_enable_bit && state == TIEC_RUN) ? {16'h0000, counter}
                                                            : 32'h0000_0000;
        tiec_pkg::ADDR_STATUS:
          prdata <= {29'h00000000, timer_output1, timer_output0, overflow_flag};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  logic unused_ok;
  assign unused_ok = ^{software_trigger_bit, external_trigger_input, capture_edge_select};
endmodule : tiec_timer

// File: tiec_timer_asserts.sv
`timescale 1ns/10ps
module tiec_timer_asserts #(
  parameter int PRESCALE = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and requests
  input wire logic timer_output0,
  input wire logic timer_output1,
  input wire logic match_irq0,
  input wire logic match_irq1
);
  logic ce;
  logic [2:0] mode;
  logic [15:0] cmp0;
  logic [15:0] cmp1;
  logic wr_go;
  logic rd_cnt;
  logic off3;
  assign wr_go = psel && penable && pwrite && clk_en && !pslverr;
  assign rd_cnt = psel && penable && !pwrite && paddr == tiec_pkg::ADDR_COUNTER;
  // shadow of the programmed state, seen from the bus only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce <= 1'b0;
      mode <= 3'h0;
      cmp0 <= 16'h0000;
      cmp1 <= 16'h0000;
    end else if (wr_go) begin
      if (paddr == tiec_pkg::ADDR_CONTROL0) ce <= pwdata[7];
      if (paddr == tiec_pkg::ADDR_CONTROL1) mode <= pwdata[2:0];
      if (paddr == tiec_pkg::ADDR_COMPARE0) cmp0 <= pwdata[15:0];
      if (paddr == tiec_pkg::ADDR_COMPARE1) cmp1 <= pwdata[15:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err:
    assert property (psel && penable && paddr > 8'h18 |-> pslverr) else $error("no slverr");
  a_read_zero_off:
    assert property (rd_cnt && !ce |-> prdata == 32'h0) else $error("count read not zero");
  a_quiet_off:
    assert property (!ce && !$past(ce) && !$past(ce, 2) |-> !match_irq0 && !match_irq1)
    else $error("irq while stopped");
  a_out_off:
    assert property (!ce && !$past(ce) && !$past(ce, 2) |-> !timer_output0 && !timer_output1)
    else $error("output high while stopped");
  a_event_no_out:
    assert property (mode == tiec_pkg::MODE_EVENT_COUNT && ce && $past(ce)
      |-> !timer_output0 && !timer_output1) else $error("output in event mode");
  a_out1_irq1:
    assert property (ce && $past(ce) && $changed(timer_output1)
      |-> (match_irq1 || $past(match_irq1)) or ##1 match_irq1) else $error("stray out1 edge");
  a_irq1_below:
    assert property (match_irq1 |-> $past(cmp1, 2) <= $past(cmp0, 2)) else $error("irq1 above");
  c_irq0: cover property (match_irq0);
  c_irq1: cover property (match_irq1);
  c_slverr: cover property (psel && penable && pslverr);
endmodule : tiec_timer_asserts
bind tiec_timer tiec_timer_asserts #(.PRESCALE(PRESCALE)) u_chk (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_output0(timer_output0), .timer_output1(timer_output1),
  .match_irq0(match_irq0), .match_irq1(match_irq1));

// File: tiec_event_src.sv
`timescale 1ns/10ps
module tiec_event_src (
  // clock
  input wire logic pclk,
  // event pin
  output logic capture_trigger_input0
);
  initial capture_trigger_input0 = 1'b0;
  // edges only on input0, one cycle high, gap sets a prompt or slow source
  task automatic edges(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      capture_trigger_input0 <= 1'b1;
      @(posedge pclk);
      capture_trigger_input0 <= 1'b0;
      repeat (gap + 1) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : edges
endmodule : tiec_event_src

// File: tiec_timer_tb.sv
`timescale 1ns/10ps
module tiec_timer_tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, external_trigger_input;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, capture_trigger_input0, timer_output0, timer_output1;
  logic match_irq0, match_irq1, overflow_irq, o0, o1, a0, a1;
  int fails = 0, n_compared = 0, cyc = 0, n0 = 0, n1 = 0, nov = 0, last0 = 0, per0 = 0, k, j;
  tiec_timer #(.PRESCALE(1)) u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_trigger_input0,
    .external_trigger_input, .timer_output0, .timer_output1, .match_irq0, .match_irq1,
    .overflow_irq);
  tiec_event_src u_ev (.pclk, .capture_trigger_input0);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // pulse bookkeeping sees pre-edge values, so no race with the design
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (match_irq0 === 1'b1) begin
      n0 <= n0 + 1;
      per0 <= cyc - last0;
      last0 <= cyc;
      o0 <= timer_output0;
      o1 <= timer_output1;
    end
    if (match_irq1 === 1'b1) n1 <= n1 + 1;
    if (overflow_irq === 1'b1) nov <= nov + 1;
  end
  task automatic end_sim;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      fails++;
      end_sim;
    end
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_irq0(input int target, input int lim);
    int i;
    i = 0;
    while (n0 < target && i < lim) begin
      @(posedge pclk);
      i++;
    end
    if (n0 < target) begin
      fails++;
      end_sim;
    end
  endtask : wait_irq0
  task automatic t_interval;
    apb(1'b0, tiec_pkg::ADDR_COUNTER, 32'h0);
    chk(v, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(v, 32'h0);
    apb(1'b1, tiec_pkg::ADDR_COMPARE0, 32'h4);
    apb(1'b1, tiec_pkg::ADDR_COMPARE1, 32'h1);
    apb(1'b1, tiec_pkg::ADDR_IO_CONTROL1, 32'h30);
    apb(1'b1, tiec_pkg::ADDR_CONTROL1, {29'h0, tiec_pkg::MODE_INTERVAL});
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h80);
    wait_irq0(n0 + 3, 100);
    chk(per0, 5);
    k = n1;
    a0 = o0;
    a1 = o1;
    wait_irq0(n0 + 1, 100);
    chk(o0, !a0);
    chk(o1, !a1);
    chk(n1, k + 1);
    apb(1'b0, tiec_pkg::ADDR_COUNTER, 32'h0);
    chk(v < 32'h5, 1);
    apb(1'b1, tiec_pkg::ADDR_COMPARE1, 32'ha);
    wait_irq0(n0 + 2, 100);
    k = n1;
    a1 = o1;
    wait_irq0(n0 + 2, 100);
    chk(n1, k);
    chk(o1, a1);
    apb(1'b1, tiec_pkg::ADDR_CONTROL1, 32'h40); // internal clock, trigger set
    external_trigger_input <= 1'b1;
    apb(1'b1, tiec_pkg::ADDR_COMPARE0, 32'h14);
    wait_irq0(n0 + 2, 200);
    chk(per0, 21);
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h0); // stop before lowering
    apb(1'b1, tiec_pkg::ADDR_COMPARE0, 32'h0);
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h80);
    wait_irq0(n0 + 3, 100);
    chk(per0, 1);
    apb(1'b0, tiec_pkg::ADDR_COUNTER, 32'h0);
    chk(v, 32'h0);
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h0);
    apb(1'b0, tiec_pkg::ADDR_COUNTER, 32'h0);
    chk(v, 32'h0);
  endtask : t_interval
  task automatic t_full_range;
    apb(1'b1, tiec_pkg::ADDR_COMPARE0, 32'hffff);
    k = cyc;
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h80);
    wait_irq0(n0 + 1, 70000);
    chk(last0 - k >= 65536 && last0 - k < 65546, 1);
    chk(nov, 0);
    apb(1'b0, tiec_pkg::ADDR_STATUS, 32'h0);
    chk(v[0], 1'b0);
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h0);
  endtask : t_full_range
  task automatic t_event;
    apb(1'b1, tiec_pkg::ADDR_CONTROL1, {29'h0, tiec_pkg::MODE_EVENT_COUNT});
    apb(1'b1, tiec_pkg::ADDR_IO_CONTROL1, 32'h30); // edge select none (unused, pin edges still count), outputs enabled
    apb(1'b1, tiec_pkg::ADDR_COMPARE0, 32'h3); // never zero here
    apb(1'b1, tiec_pkg::ADDR_COMPARE1, 32'h1);
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h80);
    k = n0;
    for (int i = 0; i < 8 && n0 == k; i++) u_ev.edges(1, 1);
    k = n0;
    j = n1;
    u_ev.edges(3, 1);
    chk(n0, k);
    apb(1'b0, tiec_pkg::ADDR_COUNTER, 32'h0);
    chk(v, 32'h3);
    u_ev.edges(1, 6);
    chk(n0, k + 1);
    chk(n1, j + 1);
    chk(o0, 1'b0);
    chk(o1, 1'b0);
  endtask : t_event
  task automatic t_pin_clock;
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h0);
    apb(1'b1, tiec_pkg::ADDR_CONTROL1, 32'h20); // interval mode on pin edges
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h80);
    u_ev.edges(1, 1);
    apb(1'b0, tiec_pkg::ADDR_STATUS, 32'h0);
    chk(v[tiec_pkg::STATUS_OUT0_POS], 1'b1);
    k = n0;
    u_ev.edges(4, 1);
    chk(n0, k + 1);
    chk(o1, 1'b1);
    apb(1'b1, tiec_pkg::ADDR_CONTROL0, 32'h0);
  endtask : t_pin_clock
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    external_trigger_input = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_interval;
    t_full_range;
    t_event;
    t_pin_clock;
    end_sim;
  end
endmodule : tiec_timer_tb
